// >>> src/dicfg_pkg.sv
// Constants and types of the digital input configuration and status block
// Contract
// (RULE1) Config write and status read share word address thirteen.
// (RULE2) Configure bit 0 clears at reset; zero means unconfigured, raising attention.
// (RULE3) Reading point data while unconfigured raises attention.
// (RULE4) Force-error bit 1 clears at reset; while set, attention and status bit 1.
// (RULE5) Configure and fuse-enable bits read back at their own positions.
// (RULE6) Status bits 2-5 and 11-15 read one; writes there do nothing.
// (RULE7) Fuse-enable bit 6 clears at reset; controller sets it to detect fuses.
// (RULE8) Status bit 7 is one only if enabled and fuse open or supply absent.
// (RULE9) Write bits 7 and 8 do nothing; status bits 8-10 reserved.
// (RULE10) Communication indicator lit while controller is communicating.
// (RULE11) External fault indicator lit while status bit 7 is set.
// (RULE12) Internal fault indicator lit on force error or watchdog timeout.
// (RULE13) Each channel indicator lit while its qualified input is on.
// (RULE14) Watchdog period is a parameter; any access restarts it and clears timeout.
// (RULE15) Attention is unconfigured OR forced error OR enabled blown fuse.
package dicfg_pkg;
  // Word index of the shared register and its byte address
  localparam logic [7:0]  DICFG_CFG_IDX   = 8'h0D;
  localparam logic [7:0]  DICFG_CFG_ADDR  = 8'h34;
  // Interrupt registers
  localparam logic [7:0]  DICFG_IRQ_STAT  = 8'h40;
  localparam logic [7:0]  DICFG_IRQ_EN    = 8'h44;
  localparam logic [7:0]  DICFG_IRQ_CLR   = 8'h48;
  // Point data word, read triggers the unconfigured check
  localparam logic [7:0]  DICFG_POINT     = 8'h00;
  // Field positions
  localparam int          DICFG_B_CONF    = 0;
  localparam int          DICFG_B_FERR    = 1;
  localparam int          DICFG_B_FEN     = 6;
  localparam int          DICFG_B_FUSE    = 7;
  localparam logic [15:0] DICFG_ONES_MASK = 16'hF83C;
  localparam logic [2:0]  DICFG_CTRL_RST  = 3'h0;
  // Interrupt status bits
  localparam int          DICFG_E_ATTN    = 0;
  localparam int          DICFG_E_WDOG    = 1;
  localparam int          DICFG_E_FUSE    = 2;
  // Watchdog: time in microseconds, and activity window in microseconds
  localparam int          DICFG_WDOG_US   = 100000;
  localparam int          DICFG_CLK_MHZ   = 250;
  localparam int          DICFG_WDOG_CYC  = DICFG_WDOG_US * DICFG_CLK_MHZ;
  localparam int          DICFG_COMM_US   = 100;
  localparam int          DICFG_COMM_CYC  = DICFG_COMM_US * DICFG_CLK_MHZ;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
endpackage

// >>> src/dicfg_top.sv
// Configuration, status, indicators and watchdog of the digital input module
`timescale 1ns/1ns
module dicfg_top
  import dicfg_pkg::*;
#(
  parameter int WDOG_CYC = DICFG_WDOG_CYC,
  parameter int COMM_CYC = DICFG_COMM_CYC
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Field side
  input  wire logic        fuse_open,
  input  wire logic [15:0] channel_on,
  // Indicators and attention
  output logic             comm_led,
  output logic             ext_fault_led,
  output logic             int_fault_led,
  output logic [15:0]      channel_state_indicators,
  output logic             attention,
  output logic             irq
);

  // Address phase capture
  logic       wr_q;
  logic       rd_q;
  logic [7:0] adr_q;
  wire        start  = hsel && hready && (htrans == HTRANS_NONSEQ);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      adr_q <= 8'h00;
    end else begin
      wr_q  <= start && hwrite;
      rd_q  <= start && !hwrite;
      adr_q <= haddr;
    end
  end

  // Control bits: configure, force error, fuse enable
  logic [2:0]  ctrl_q;
  logic [2:0]  irq_st_q;
  logic [2:0]  irq_en_q;
  logic        wdog_to_q;
  logic [31:0] wdog_cnt_q;
  logic [31:0] comm_cnt_q;
  logic        attn_pt_q;
  wire  wr_cfg = wr_q && (adr_q == DICFG_CFG_ADDR); // RULE1
  wire  wr_en  = wr_q && (adr_q == DICFG_IRQ_EN);
  wire  wr_clr = wr_q && (adr_q == DICFG_IRQ_CLR);
  wire  rd_pt  = rd_q && (adr_q == DICFG_POINT);
  wire  access = wr_q || rd_q;
  // Only bits 0, 1 and 6 are stored; others ignored
  wire [2:0] ctrl_d = wr_cfg ? {hwdata[DICFG_B_FEN], hwdata[DICFG_B_FERR],
                                hwdata[DICFG_B_CONF]} : ctrl_q; // RULE6 RULE9
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ctrl_q <= DICFG_CTRL_RST; // RULE2 RULE4 RULE7
    else          ctrl_q <= ctrl_d;
  end

  // Status word assembly
  wire conf    = ctrl_q[0];
  wire ferr    = ctrl_q[1];
  wire fen     = ctrl_q[2];
  wire blown   = fen && fuse_open; // RULE8
  wire [15:0] status = DICFG_ONES_MASK // RULE6
                     | (16'(conf)  << DICFG_B_CONF) // RULE5
                     | (16'(ferr)  << DICFG_B_FERR) // RULE4
                     | (16'(fen)   << DICFG_B_FEN) // RULE5
                     | (16'(blown) << DICFG_B_FUSE); // RULE8 RULE9
  // Attention from unconfigured point read is sticky until configured
  wire attn_d  = !conf || ferr || blown || attn_pt_q; // RULE15 RULE2
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)            attn_pt_q <= 1'b0;
    else if (rd_pt && !conf) attn_pt_q <= 1'b1; // RULE3
    else if (conf)           attn_pt_q <= 1'b0;
  end

  // Watchdog expiry: the counter has reached the last cycle of the period
  wire wdog_exp  = (wdog_cnt_q == 32'(WDOG_CYC - 1));
  // Activity window still open
  wire comm_open = (comm_cnt_q != 32'h0);

  // Watchdog counter: any completed access restarts it, it holds at expiry
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdog_cnt_q <= 32'h0;
    end else if (access) begin
      wdog_cnt_q <= 32'h0; // RULE14
    end else if (!wdog_exp) begin
      wdog_cnt_q <= wdog_cnt_q + 32'h1;
    end
  end

  // Timeout flag: set at expiry, cleared by the next access
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdog_to_q <= 1'b0;
    end else if (access) begin
      wdog_to_q <= 1'b0; // RULE14
    end else if (wdog_exp) begin
      wdog_to_q <= 1'b1; // RULE14
    end
  end

  // Activity window: reloaded on access, counts down to zero when idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      comm_cnt_q <= 32'h0;
    end else if (access) begin
      comm_cnt_q <= 32'(COMM_CYC); // RULE10
    end else if (comm_open) begin
      comm_cnt_q <= comm_cnt_q - 32'h1;
    end
  end

  // Interrupt status: set wins over clear
  wire [2:0] ev   = {blown, wdog_exp && !access, rd_pt && !conf};
  wire [2:0] clrm = wr_clr ? hwdata[2:0] : 3'h0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_st_q <= 3'h0;
      irq_en_q <= 3'h0;
    end else begin
      irq_st_q <= (irq_st_q & ~clrm) | ev;
      irq_en_q <= wr_en ? hwdata[2:0] : irq_en_q;
    end
  end

  // Read data select, registered in the address phase
  wire [31:0] rd_d = (haddr == DICFG_CFG_ADDR) ? {16'h0, status} : // RULE1
                     (haddr == DICFG_IRQ_STAT) ? {29'h0, irq_st_q} :
                     (haddr == DICFG_IRQ_EN)   ? {29'h0, irq_en_q} :
                     (haddr == DICFG_POINT)    ? {16'h0, channel_on} : 32'h0;

  // Next values of the registered outputs
  wire        rd_start = start && !hwrite;
  wire [31:0] hrdata_d = rd_start ? rd_d : 32'h0;
  wire        comm_d   = access || (comm_cnt_q > 32'h1);
  wire        intf_d   = ferr || wdog_to_q;
  wire        irq_d    = |(irq_st_q & irq_en_q);

  // Read data: stands for the data phase only, zero otherwise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else begin
      hrdata <= hrdata_d; // RULE1
    end
  end

  // Bus answer: never stalls, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Communication indicator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      comm_led <= 1'b0;
    end else begin
      comm_led <= comm_d; // RULE10
    end
  end

  // External fault indicator follows status bit 7
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_fault_led <= 1'b0;
    end else begin
      ext_fault_led <= blown; // RULE11
    end
  end

  // Internal fault indicator: forced error or watchdog timeout
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_fault_led <= 1'b0;
    end else begin
      int_fault_led <= intf_d; // RULE12
    end
  end

  // Per-channel indicators copy the qualified inputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_state_indicators <= 16'h0;
    end else begin
      channel_state_indicators <= channel_on; // RULE13
    end
  end

  // Attention: high from reset, since the module starts unconfigured
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      attention <= 1'b1;
    end else begin
      attention <= attn_d; // RULE15
    end
  end

  // Level interrupt from enabled sticky status bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_d;
    end
  end

endmodule

// >>> bench/dicfg_props.sv
// Port checker of the configuration and status block
`timescale 1ns/1ns
module dicfg_props #(parameter int WDOG_CYC = 50, parameter int COMM_CYC = 10) (
  // Bus
  input wire logic        hclk, hresetn, hsel, hready, hreadyout, hresp,
  input wire logic [1:0]  htrans,
  input wire logic [31:0] hrdata,
  // Field and indicators
  input wire logic        fuse_open, comm_led, ext_fault_led, int_fault_led, attention,
  input wire logic [15:0] channel_on, channel_state_indicators
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire         take = hsel && hready && htrans == 2'h2;
  logic [15:0] idle_q;
  sequence s_take; take; endsequence
  sequence s_calm; !fuse_open [*3]; endsequence
  // Cycles since the last accepted transfer, saturating
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) idle_q <= 16'h0;
    else idle_q <= take ? 16'h0 : idle_q + {15'h0, idle_q != 16'hFFFF};
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bad answer");
  a_rdata_idle: assert property (!take |=> hrdata == 32'h0) else $error("stray data");
  a_chan_copy: assert property (channel_state_indicators == $past(channel_on))
    else $error("channel led");
  a_ext_calm: assert property (s_calm |-> !ext_fault_led) else $error("ext led");
  a_attn_fuse: assert property ($rose(ext_fault_led) |-> attention) else $error("attn");
  a_comm_on: assert property (s_take |-> ##[1:3] comm_led) else $error("comm dark");
  a_comm_off: assert property (idle_q > COMM_CYC + 3 |-> !comm_led) else $error("comm lit");
  a_wdog_trip: assert property (idle_q > WDOG_CYC + 3 |-> int_fault_led) else $error("wdog");
endmodule
bind dicfg_top dicfg_props #(.WDOG_CYC(WDOG_CYC), .COMM_CYC(COMM_CYC)) chk_u (.hclk, .hresetn,
  .hsel, .hready, .hreadyout, .hresp, .htrans, .hrdata, .fuse_open, .comm_led, .ext_fault_led,
  .int_fault_led, .attention, .channel_on, .channel_state_indicators);

// >>> bench/dicfg_field.sv
// Field side model: supply fuse monitor and qualified channel inputs
`timescale 1ns/1ns
module dicfg_field (
  // Clock, bench commands, lines into the block
  input wire logic        hclk,
  input wire logic        blow,
  input wire logic [15:0] pat,
  output logic            fuse_open,
  output logic [15:0]     channel_on
);
  // Levels settle one cycle after the command, like the front end
  always_ff @(posedge hclk) begin
    fuse_open  <= blow;
    channel_on <= pat;
  end
endmodule

// >>> bench/tb.sv
// Self-checking bench of the configuration and status block
`timescale 1ns/1ns
module tb;
  import dicfg_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, blow = 0;
  logic [1:0]  htrans = 2'h0;
  logic [7:0]  haddr = 8'h0;
  logic [15:0] pat = 16'h0;
  logic [31:0] hwdata = 32'h0, r;
  wire  [31:0] hrdata;
  wire  [15:0] chan_on, chan_led;
  wire         hreadyout, fuse, comm, ext, intf, attn, irq;
  wire  [31:0] leds = {28'h0, comm, attn, intf, ext};
  int          n_fail = 0, tests_run = 0, cyc = 0;
  always #2 hclk = ~hclk;
  dicfg_field fld_u (.hclk(hclk), .blow(blow), .pat(pat), .fuse_open(fuse), .channel_on(chan_on));
  dicfg_top #(.WDOG_CYC(50), .COMM_CYC(10)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .fuse_open(fuse),
    .channel_on(chan_on), .comm_led(comm), .ext_fault_led(ext), .int_fault_led(intf),
    .channel_state_indicators(chan_led), .attention(attn), .irq(irq));
  // Verdict and end of run
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One single-word transfer: address phase, then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  task automatic st;
    repeat (3) @(posedge hclk);
    #1;
  endtask
  // Reset values, point read while unconfigured, interrupt, unmapped place
  task automatic t_boot;
    st;
    chk(leds, 32'h4);
    rd(DICFG_CFG_ADDR, 32'hF83C);
    pat <= 16'hA5C3;
    rd(DICFG_POINT, 32'hA5C3);
    chk({16'h0, chan_led}, 32'hA5C3);
    rd(DICFG_IRQ_STAT, 32'h1);
    ahb(1'b1, DICFG_IRQ_EN, 32'h1);
    st;
    chk({31'h0, irq}, 32'h1);
    ahb(1'b1, DICFG_IRQ_CLR, 32'h1);
    st;
    chk({31'h0, irq}, 32'h0);
    rd(8'h80, 32'h0);
  endtask
  // Control bits, dead write bits, blown fuse with and without enable
  task automatic t_cfg;
    ahb(1'b1, DICFG_CFG_ADDR, 32'hFFFF);
    rd(DICFG_CFG_ADDR, 32'hF87F);
    st;
    chk(leds, 32'hE);
    ahb(1'b1, DICFG_CFG_ADDR, 32'h41);
    rd(DICFG_CFG_ADDR, 32'hF87D);
    @(posedge hclk);
    blow <= 1'b1;
    rd(DICFG_CFG_ADDR, 32'hF8FD);
    st;
    chk(leds, 32'hD);
    ahb(1'b1, DICFG_CFG_ADDR, 32'h1);
    rd(DICFG_CFG_ADDR, 32'hF83D);
    st;
    chk(leds, 32'h8);
  endtask
  // Silence trips the watchdog; the next access clears it
  task automatic t_wdog;
    repeat (60) @(posedge hclk);
    #1;
    chk(leds, 32'h2);
    rd(DICFG_IRQ_STAT, 32'h6);
    st;
    chk(leds, 32'h8);
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_boot;
    t_cfg;
    t_wdog;
    conclude;
  end
  // Cuts a hung run short
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 1000) begin
      n_fail++;
      conclude;
    end
  end
endmodule
